// ---- pkg/rpmd_regs.svh ----
// register offsets, field positions and reset values of the port misc/debug bank
// assumes a byte-wide register port behind the device's serial control target
`ifndef RPMD_REGS_SVH
`define RPMD_REGS_SVH

`define RPMD_NUM_PORTS 2
`define RPMD_NUM_PINS 7

`define RPMD_ADDR_PORT_SELECT 8'h4C
`define RPMD_ADDR_FV_MIN 8'hBC
`define RPMD_ADDR_RSVD_BD 8'hBD
`define RPMD_ADDR_PD_DISABLE 8'hBE
`define RPMD_ADDR_RSVD_BF 8'hBF
`define RPMD_ADDR_PORT_DEBUG 8'hD0

`define RPMD_RST_FV_MIN 8'h00
`define RPMD_RST_RSVD 8'h00
`define RPMD_RST_PD_DISABLE 7'h00
`define RPMD_RST_PORT_DEBUG 8'h00
`define RPMD_RST_WR_SEL 2'h1
`define RPMD_RST_RD_SEL 1'h0

// port select: bits 1:0 write enables per port, bit 4 read port index
`define RPMD_SEL_WR_LSB 0
`define RPMD_SEL_WR_MSB 1
`define RPMD_SEL_RD_BIT 4

// port debug fields
`define RPMD_DBG_ONE_BIT 0
`define RPMD_DBG_CONT_BIT 1
`define RPMD_DBG_SELFTEST_BIT 5
`define RPMD_DBG_RW_MASK 8'hDF

`define RPMD_BYTE_ZERO 8'h00
`define RPMD_COUNT_ONE 8'h01
`define RPMD_COUNT_MAX 8'hFF

`endif

// ---- pkg/rpmd_pkg.sv ----
// state types of the port misc/debug register bank
// assumes rpmd_regs.svh is on the include path
`default_nettype none

package rpmd_pkg;

	typedef struct packed {
		logic [7:0] debugCtl;
		logic selftest;
		logic armed;
		logic [7:0] fvCount;
		logic fvFired;
		logic frameStart;
		logic bcCorrupt;
		logic [7:0] debugRead;
	} rpmd_port_s;

	typedef struct packed {
		logic [7:0] fvMinDuration;
		logic [7:0] rsvdBd;
		logic [6:0] pdDisable;
		logic [7:0] rsvdBf;
		logic [1:0] wrSel;
		logic rdSel;
		logic [7:0] rdData;
		logic [6:0] pulldownEn;
	} rpmd_top_s;

endpackage : rpmd_pkg

`default_nettype wire

// ---- rtl/rpmd_port.sv ----
// one receive port: debug register, frame valid qualifier, back-channel error injection
// assumes one clock, synchronous inputs and write strobes already routed to this port
`default_nettype none
`include "rpmd_regs.svh"

module rpmd_port
	import rpmd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register access
	input wire logic debugWrEn,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] fvMinDuration,
	// link side
	input wire logic rawMode,
	input wire logic frameValid,
	input wire logic remoteSelftest,
	input wire logic bcFrameStrobe,
	// results
	output logic [7:0] debugRead,
	output logic frameStart,
	output logic bcCorrupt
);

	rpmd_port_s st;
	rpmd_port_s next_st;
	logic writeOne;

	always_comb begin
		next_st = st;
		writeOne = debugWrEn && regWrData[`RPMD_DBG_ONE_BIT];
		if (debugWrEn) begin
			next_st.debugCtl = regWrData & `RPMD_DBG_RW_MASK;
		end
		// arm only on a 0-to-1 write of the single-shot bit
		if (writeOne && !st.debugCtl[`RPMD_DBG_ONE_BIT]) begin
			next_st.armed = 1'b1;
		end
		next_st.bcCorrupt = 1'b0;
		if (bcFrameStrobe) begin
			if (st.debugCtl[`RPMD_DBG_CONT_BIT]) begin
				next_st.bcCorrupt = 1'b1;
			end else if (st.armed) begin
				next_st.bcCorrupt = 1'b1;
			end
			// a frame consumes the armed error; a new arm in this cycle survives
			if (st.armed && !(writeOne && !st.debugCtl[`RPMD_DBG_ONE_BIT])) begin
				next_st.armed = 1'b0;
			end
		end
		// in raw mode, frame start only after frame valid stayed high long enough; otherwise on its first high cycle
		next_st.frameStart = 1'b0;
		if (!frameValid) begin
			next_st.fvCount = `RPMD_BYTE_ZERO;
			next_st.fvFired = 1'b0;
		end else begin
			if (st.fvCount != `RPMD_COUNT_MAX) begin
				next_st.fvCount = st.fvCount + `RPMD_COUNT_ONE;
			end
			if (!st.fvFired && (!rawMode || (st.fvCount >= fvMinDuration))) begin
				next_st.frameStart = 1'b1;
				next_st.fvFired = 1'b1;
			end
		end
		next_st.selftest = remoteSelftest;
		next_st.debugRead = next_st.debugCtl;
		next_st.debugRead[`RPMD_DBG_SELFTEST_BIT] = next_st.selftest;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.debugCtl <= `RPMD_RST_PORT_DEBUG;
			st.debugRead <= `RPMD_RST_PORT_DEBUG;
		end else begin
			st <= next_st;
		end
	end

	assign debugRead = st.debugRead;
	assign frameStart = st.frameStart;
	assign bcCorrupt = st.bcCorrupt;

endmodule : rpmd_port

`default_nettype wire

// ---- rtl/rpmd_top.sv ----
// port misc/debug register bank: frame valid minimum, pin pulldown control, per-port debug
// assumes a byte register port from the serial control target, one read cycle latency,
// and synchronous link-side inputs on the same clock
`default_nettype none
`include "rpmd_regs.svh"

////////////////////////////////////////////////////////////////////////////////

module rpmd_top
	import rpmd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// pins
	input wire logic [6:0] pinIsOutput,
	output logic [6:0] pulldownEn,
	// receive ports
	input wire logic [1:0] rawMode,
	input wire logic [1:0] frameValid,
	input wire logic [1:0] remoteSelftest,
	input wire logic [1:0] bcFrameStrobe,
	output logic [1:0] frameStart,
	output logic [1:0] bcCorrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
		addrHit = (addr == target);
	endfunction : addrHit

	rpmd_top_s st;
	rpmd_top_s next_st;
	logic [1:0] debugWrEn;
	logic [7:0] debugRead [`RPMD_NUM_PORTS];
	logic [7:0] portSelRead;

	////////////////////////////////////////////////////////////////////////////////
	// per-port debug blocks

	genvar gp;
	generate
		for (gp = 0; gp < `RPMD_NUM_PORTS; gp = gp + 1) begin : g_port
			// a write lands only on ports enabled in the select register
			assign debugWrEn[gp] = regWrEn && addrHit(regAddr, `RPMD_ADDR_PORT_DEBUG)
				&& st.wrSel[gp];

			rpmd_port u_port (
				.clk(clk),
				.rst_n(rst_n),
				.debugWrEn(debugWrEn[gp]),
				.regWrData(regWrData),
				.fvMinDuration(st.fvMinDuration),
				.rawMode(rawMode[gp]),
				.frameValid(frameValid[gp]),
				.remoteSelftest(remoteSelftest[gp]),
				.bcFrameStrobe(bcFrameStrobe[gp]),
				.debugRead(debugRead[gp]),
				.frameStart(frameStart[gp]),
				.bcCorrupt(bcCorrupt[gp])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// shared registers and read mux

	always_comb begin
		next_st = st;
		portSelRead = `RPMD_BYTE_ZERO;
		portSelRead[`RPMD_SEL_WR_MSB:`RPMD_SEL_WR_LSB] = st.wrSel;
		portSelRead[`RPMD_SEL_RD_BIT] = st.rdSel;
		if (regWrEn) begin
			if (addrHit(regAddr, `RPMD_ADDR_FV_MIN)) begin
				next_st.fvMinDuration = regWrData;
			end
			if (addrHit(regAddr, `RPMD_ADDR_RSVD_BD)) begin
				next_st.rsvdBd = regWrData;
			end
			if (addrHit(regAddr, `RPMD_ADDR_PD_DISABLE)) begin
				next_st.pdDisable = regWrData[`RPMD_NUM_PINS-1:0];
			end
			if (addrHit(regAddr, `RPMD_ADDR_RSVD_BF)) begin
				next_st.rsvdBf = regWrData;
			end
			if (addrHit(regAddr, `RPMD_ADDR_PORT_SELECT)) begin
				next_st.wrSel = regWrData[`RPMD_SEL_WR_MSB:`RPMD_SEL_WR_LSB];
				next_st.rdSel = regWrData[`RPMD_SEL_RD_BIT];
			end
		end
		if (regRdEn) begin
			case (regAddr)
				`RPMD_ADDR_FV_MIN: begin
					next_st.rdData = st.fvMinDuration;
				end
				`RPMD_ADDR_RSVD_BD: begin
					next_st.rdData = st.rsvdBd;
				end
				`RPMD_ADDR_PD_DISABLE: begin
					next_st.rdData = {1'b0, st.pdDisable};
				end
				`RPMD_ADDR_RSVD_BF: begin
					next_st.rdData = st.rsvdBf;
				end
				`RPMD_ADDR_PORT_SELECT: begin
					next_st.rdData = portSelRead;
				end
				`RPMD_ADDR_PORT_DEBUG: begin
					next_st.rdData = debugRead[st.rdSel];
				end
				default: begin
					next_st.rdData = `RPMD_BYTE_ZERO;
				end
			endcase
		end
		// pulldown on at pins not set as output, unless disabled
		next_st.pulldownEn = ~pinIsOutput & ~st.pdDisable;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.fvMinDuration <= `RPMD_RST_FV_MIN;
			st.rsvdBd <= `RPMD_RST_RSVD;
			st.pdDisable <= `RPMD_RST_PD_DISABLE;
			st.rsvdBf <= `RPMD_RST_RSVD;
			st.wrSel <= `RPMD_RST_WR_SEL;
			st.rdSel <= `RPMD_RST_RD_SEL;
			st.rdData <= `RPMD_BYTE_ZERO;
			st.pulldownEn <= `RPMD_RST_PD_DISABLE;
		end else begin
			st <= next_st;
		end
	end

	assign regRdData = st.rdData;
	assign pulldownEn = st.pulldownEn;

endmodule : rpmd_top

`default_nettype wire

// ---- verif/rpmd_monitor.sv ----
// assertions and covers on the port misc/debug bank ports
// assumes a bind to rpmd_top, one clock and a synchronous active-low reset
`default_nettype none

module rpmd_monitor
	import rpmd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regRdData,
	// pins
	input wire logic [6:0] pinIsOutput,
	input wire logic [6:0] pulldownEn,
	// receive ports
	input wire logic [1:0] rawMode,
	input wire logic [1:0] frameValid,
	input wire logic [1:0] bcFrameStrobe,
	input wire logic [1:0] frameStart,
	input wire logic [1:0] bcCorrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	chk_pd_output_off: assert property (1 |=> (pulldownEn & $past(pinIsOutput)) == 7'h00)
		else $error("pulldown on at output pin");
	chk_bc_has_strobe: assert property ((bcCorrupt & ~$past(bcFrameStrobe)) == 2'b00)
		else $error("corrupt without frame");
	chk_fs_one_cycle: assert property ((frameStart & $past(frameStart)) == 2'b00)
		else $error("frame start too long");
	chk_fs_has_valid: assert property ((frameStart & ~$past(frameValid)) == 2'b00)
		else $error("frame start without valid");
	chk_fs_direct: assert property (!rawMode[1] && frameValid[1] && !$past(frameValid[1])
		|=> frameStart[1]) else $error("no direct frame start");
	chk_rd_bit7_zero: assert property (regRdEn && regAddr == 8'hbe |=> !regRdData[7])
		else $error("reserved bit set");
	chk_rd_unmapped: assert property (regRdEn && regAddr == 8'h00 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	chk_rd_hold: assert property (!$past(regRdEn) |-> $stable(regRdData))
		else $error("read data moved");
	cover property (frameStart[0]);
	cover property (bcCorrupt[0]);
	cover property (bcCorrupt[1]);
endmodule : rpmd_monitor

bind rpmd_top rpmd_monitor i_rpmd_monitor (.clk, .rst_n, .regRdEn, .regAddr, .regRdData,
	.pinIsOutput, .pulldownEn, .rawMode, .frameValid, .bcFrameStrobe, .frameStart, .bcCorrupt);

`default_nettype wire

// ---- verif/rpmd_link_model.sv ----
// link-side stand-in: frame valid bursts and back-channel frame timing
// assumes one clock; outputs change just after the rising edge
`default_nettype none

module rpmd_link_model (
	// clock
	input wire logic clk,
	// burst request
	input wire logic go,
	input wire logic [7:0] len,
	// link outputs
	output logic fv,
	output logic [1:0] bcStrobe
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	int ph = 0;
	initial begin
		fv = 1'b0;
		bcStrobe = 2'b00;
	end
	// a frame every five cycles; a burst stays high len+1 cycles, then low
	always @(posedge clk) begin
		ph <= (ph + 1) % 5;
		bcStrobe <= {2{ph == 0}};
		if (go && !fv) begin
			fv <= 1'b1;
			cnt <= len;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else begin
			fv <= 1'b0;
		end
	end
endmodule : rpmd_link_model

`default_nettype wire

// ---- verif/rpmd_top_test.sv ----
// self-checking bench for the port misc/debug bank
// assumes rpmd_top, rpmd_link_model and the bound monitor
`default_nettype none
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin numErrors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end

module rpmd_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, go = 0, rdSeen = 0, fv;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, len = 8'h00, d, e;
	logic [6:0] pinIsOutput = 7'h00, pulldownEn;
	logic [1:0] rawMode = 2'b01, remoteSelftest = 2'b01, frameStart, bcCorrupt, bcs;
	logic [7:0] expQ[$];
	logic [7:0] ra[7] = '{8'h4c, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hd0, 8'h00};
	logic [7:0] re[7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
	logic [7:0] sq[4] = '{8'h01, 8'h01, 8'h00, 8'h01};
	int ne[4] = '{1, 1, 1, 2};
	int numErrors = 0, nCompared = 0, c, bc[2] = '{0, 0}, fs[2] = '{0, 0};
	int seed = 32'he0a4;

	rpmd_top i_rpmd_top (.clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
		.pinIsOutput, .pulldownEn, .rawMode, .frameValid({fv, fv}), .remoteSelftest,
		.bcFrameStrobe(bcs), .frameStart, .bcCorrupt);
	rpmd_link_model i_rpmd_link_model (.clk, .go, .len, .fv, .bcStrobe(bcs));

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) rdSeen <= regRdEn;
	// read results against the oldest note; event counters
	always @(negedge clk) begin
		for (int i = 0; i < 2; i++) begin
			bc[i] += bcCorrupt[i];
			fs[i] += frameStart[i];
		end
		if (rdSeen) begin
			e = expQ.pop_front();
			`CHK(regRdData, e)
		end
	end
	////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		regWrEn = w;
		regRdEn = !w;
		regAddr = a;
		regWrData = v;
		if (!w) expQ.push_back(v);
		@(negedge clk);
		regWrEn = 0;
		regRdEn = 0;
	endtask : acc
	task automatic test_done();
		$display("errors %0d compared %0d", numErrors, nCompared);
		if (numErrors == 0 && nCompared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	initial begin
		cyc(3000);
		numErrors++;
		test_done();
	end
	initial begin
		cyc(10);
		rst_n = 1;
		foreach (ra[i]) acc(0, ra[i], re[i]);
		for (int i = 1; i < 5; i++) begin
			d = 8'($random(seed));
			acc(1, ra[i], d);
			acc(0, ra[i], d & (i == 3 ? 8'h7f : 8'hff));
		end
		repeat (4) begin
			d = 8'($random(seed));
			pinIsOutput = 7'($random(seed));
			acc(1, 8'hbe, d);
			cyc(1);
			`CHK(pulldownEn, ~pinIsOutput & ~d[6:0])
		end
		remoteSelftest = 2'b10;
		acc(1, 8'h4c, 8'h10);
		acc(0, 8'hd0, 8'h20);
		acc(1, 8'h4c, 8'h01);
		acc(0, 8'hd0, 8'h00);
		foreach (sq[i]) begin
			acc(1, 8'hd0, sq[i]);
			cyc(12);
			`CHK(bc[0], ne[i])
		end
		`CHK(bc[1], 0)
		acc(1, 8'h4c, 8'h02);
		acc(1, 8'hd0, 8'h02);
		// sample the counters between falling edges so the counting process cannot race them
		@(posedge clk);
		c = bc[1];
		repeat (20) @(posedge clk);
		`CHK(bc[1] - c, 4)
		`CHK(bc[0], 2)
		acc(1, 8'h4c, 8'h01);
		acc(1, 8'hbc, 8'h03);
		for (int i = 3; i > 1; i--) begin
			len = 8'(i);
			go = 1;
			cyc(1);
			go = 0;
			cyc(10);
		end
		`CHK(fs[0], 1)
		`CHK(fs[1], 2)
		test_done();
	end
endmodule : rpmd_top_test

`default_nettype wire
